/* sct_regs.svh */
// Function
// RL1: counter advances once per selected clock pulse
// RL2: continuous compare; match clears, interrupts, toggles
// RL3: two independent 8-bit halves, low and high
// RL4: prescaler divides system clock by 32/16/4
// RL5: write-only control selects clock, output level
// RL6: both counters readable and writable by software
// RL7: settings block match clear, enable overflow interrupt
// RL8: low match toggles pin, sets flag, interrupts
// RL9: software presets toggle level before counting
// RL10: waveform repeats without rewriting compare value
// RL11: high half mirrors low half behaviour
// RL12: software clears match flag before next interrupt
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH

// byte offsets on the register bus
`define SCT_OFF_CTRL 8'h00
`define SCT_OFF_CTRL_STAT 8'h04
`define SCT_OFF_LOW_CNT 8'h08
`define SCT_OFF_HIGH_CNT 8'h0C
`define SCT_OFF_LOW_CMP 8'h10
`define SCT_OFF_HIGH_CMP 8'h14
`define SCT_OFF_IRQ_STAT 8'h18
`define SCT_OFF_IRQ_MASK 8'h1C

// tone_timer_control fields
`define SCT_CTRL_SEL_LSB 0
`define SCT_CTRL_SEL_MSB 1
`define SCT_CTRL_LOW_LVL 2
`define SCT_CTRL_HIGH_LVL 3

// timer_ctrl_status fields
`define SCT_CS_LOW_NOCLR 0
`define SCT_CS_HIGH_NOCLR 1
`define SCT_CS_LOW_TOG 4
`define SCT_CS_HIGH_TOG 5

// interrupt status and mask layout
`define SCT_EV_LOW_MATCH 0
`define SCT_EV_HIGH_MATCH 1
`define SCT_EV_LOW_OVF 2
`define SCT_EV_HIGH_OVF 3
`define SCT_EV_W 4

// reset values
`define SCT_RST_NOCLR 2'h0
`define SCT_RST_MASK 4'h0
`define SCT_RST_STAT 4'h0

// prescaler terminal counts
`define SCT_PRESC_W 5
`define SCT_DIV32_TC 5'h1F
`define SCT_DIV16_TC 4'hF
`define SCT_DIV4_TC 2'h3

`endif

/* sct_pkg.sv */
package sct_pkg;

    typedef enum logic [1:0] {
        SCT_CLK_DIV32,
        SCT_CLK_DIV16,
        SCT_CLK_DIV4,
        SCT_CLK_STOP
    } sct_clk_sel_t;

endpackage

/* sct_half.sv */
`timescale 1ns/1ps
`default_nettype none
module sct_half #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // count control
    input wire logic tick,
    input wire logic [W-1:0] cmp_val,
    input wire logic no_clear,
    // software access
    input wire logic cnt_wr,
    input wire logic [W-1:0] cnt_wdata,
    input wire logic tog_wr,
    input wire logic tog_wdata,
    // results
    output logic [W-1:0] cnt,
    output logic tog,
    output logic match,
    output logic ovf
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tog;
        logic match;
        logic ovf;
    } sct_half_state_t;

    sct_half_state_t s;
    sct_half_state_t n;
    logic hit;

    assign hit = (s.cnt == cmp_val);

    always_comb
    begin
        n = s;
        n.match = 1'b0;
        n.ovf = 1'b0;
        // RL1: step per tick
        if (tick)
        begin
            // RL2: compare on every tick
            if (hit)
            begin
                // RL8: toggle and flag together
                n.tog = ~s.tog;
                n.match = 1'b1;
                // RL7: optional clear on match
                n.cnt = no_clear ? W'(s.cnt + 1'b1) : '0;
            end
            else
            begin
                n.cnt = W'(s.cnt + 1'b1);
            end
            if (&s.cnt && !(hit && !no_clear))
            begin
                n.ovf = 1'b1;
            end
        end
        // RL6: software write wins over counting
        if (cnt_wr)
        begin
            n.cnt = cnt_wdata;
        end
        // RL9: preset toggle level
        if (tog_wr)
        begin
            n.tog = tog_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign cnt = s.cnt;
    assign tog = s.tog;
    assign match = s.match;
    assign ovf = s.ovf;

    sequence s_hit_tick;
        tick && hit && !cnt_wr && !tog_wr;
    endsequence

    chk_match_toggle: assert property (@(posedge pclk) disable iff (!presetn) // RL8
        s_hit_tick |=> (tog != $past(tog)) && match)
    else $error("match did not toggle and flag");

    chk_match_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        s_hit_tick and !no_clear |=> cnt == '0)
    else $error("match did not clear counter");

    chk_count_step: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        tick && !hit && !cnt_wr |=> cnt == W'($past(cnt) + 1'b1))
    else $error("counter did not step by one");

    chk_count_hold: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        !tick && !cnt_wr |=> $stable(cnt) && !match)
    else $error("counter moved without tick");

endmodule
`default_nettype wire

/* sct_timer.sv */
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sct_regs.svh"
module sct_timer #(
    parameter int CNT_W = 8,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // toggle outputs to the mixer
    output logic low_toggle_out,
    output logic high_toggle_out,
    // interrupt
    output logic irq
);

    if (CNT_W < 2 || CNT_W > 32)
    begin : g_bad_cnt_w
        $error("CNT_W must lie between 2 and 32");
    end
    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 32");
    end

    typedef struct packed {
        logic [`SCT_PRESC_W-1:0] presc;
        sct_pkg::sct_clk_sel_t clk_sel;
        logic [1:0] no_clear;
        logic [1:0][CNT_W-1:0] cmp;
        logic [`SCT_EV_W-1:0] stat;
        logic [`SCT_EV_W-1:0] mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sct_state_t;

    localparam sct_state_t ST_RST = '{
        presc: '0,
        clk_sel: sct_pkg::SCT_CLK_STOP,
        no_clear: `SCT_RST_NOCLR,
        cmp: '0,
        stat: `SCT_RST_STAT,
        mask: `SCT_RST_MASK,
        irq: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: '0
    };

    sct_state_t s;
    sct_state_t n;

    logic tick;
    logic setup_ph;
    logic wr_fire;
    logic [1:0] cnt_wr;
    logic [1:0] tog_wr;
    logic [1:0] tog_wdata;
    logic [1:0][CNT_W-1:0] cnt_q;
    logic [1:0] tog_q;
    logic [1:0] match_q;
    logic [1:0] ovf_q;
    logic [`SCT_EV_W-1:0] ev;

    // RL4: divide by 32, 16 or 4
    function automatic logic tick_of(sct_pkg::sct_clk_sel_t sel, logic [`SCT_PRESC_W-1:0] p);
        logic t;
        t = 1'b0;
        unique case (sel)
            sct_pkg::SCT_CLK_DIV32: t = (p == `SCT_DIV32_TC);
            sct_pkg::SCT_CLK_DIV16: t = (p[3:0] == `SCT_DIV16_TC);
            sct_pkg::SCT_CLK_DIV4: t = (p[1:0] == `SCT_DIV4_TC);
            sct_pkg::SCT_CLK_STOP: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic is_addr(logic [ADDR_W-1:0] a, logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    function automatic logic is_mapped(logic [ADDR_W-1:0] a);
        return is_addr(a, `SCT_OFF_CTRL) || is_addr(a, `SCT_OFF_CTRL_STAT) ||
            is_addr(a, `SCT_OFF_LOW_CNT) || is_addr(a, `SCT_OFF_HIGH_CNT) ||
            is_addr(a, `SCT_OFF_LOW_CMP) || is_addr(a, `SCT_OFF_HIGH_CMP) ||
            is_addr(a, `SCT_OFF_IRQ_STAT) || is_addr(a, `SCT_OFF_IRQ_MASK);
    endfunction

    assign tick = tick_of(s.clk_sel, s.presc);
    assign setup_ph = psel && !penable && !s.pready;
    // one wait-free access: the write lands on the edge that sees pready high
    assign wr_fire = psel && penable && s.pready && pwrite && is_mapped(paddr);

    assign cnt_wr[0] = wr_fire && is_addr(paddr, `SCT_OFF_LOW_CNT);
    assign cnt_wr[1] = wr_fire && is_addr(paddr, `SCT_OFF_HIGH_CNT);
    // RL9: control write presets both levels
    assign tog_wr[0] = wr_fire && is_addr(paddr, `SCT_OFF_CTRL);
    assign tog_wr[1] = tog_wr[0];
    assign tog_wdata[0] = pwdata[`SCT_CTRL_LOW_LVL];
    assign tog_wdata[1] = pwdata[`SCT_CTRL_HIGH_LVL];

    // RL3: two independent halves
    // RL11: high half built like the low one
    for (genvar i = 0; i < 2; i++)
    begin : g_half
        sct_half #(
            .W(CNT_W)
        ) u_half (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick),
            .cmp_val(s.cmp[i]),
            .no_clear(s.no_clear[i]),
            .cnt_wr(cnt_wr[i]),
            .cnt_wdata(pwdata[CNT_W-1:0]),
            .tog_wr(tog_wr[i]),
            .tog_wdata(tog_wdata[i]),
            .cnt(cnt_q[i]),
            .tog(tog_q[i]),
            .match(match_q[i]),
            .ovf(ovf_q[i])
        );
    end

    always_comb
    begin
        ev = '0;
        ev[`SCT_EV_LOW_MATCH] = match_q[0];
        ev[`SCT_EV_HIGH_MATCH] = match_q[1];
        ev[`SCT_EV_LOW_OVF] = ovf_q[0];
        ev[`SCT_EV_HIGH_OVF] = ovf_q[1];
    end

    always_comb
    begin
        n = s;
        // free-running prescaler shared by all clock choices
        n.presc = `SCT_PRESC_W'(s.presc + 1'b1);

        if (setup_ph)
        begin
            n.pready = 1'b1;
            n.pslverr = !is_mapped(paddr);
            n.prdata = '0;
            if (!pwrite)
            begin
                if (is_addr(paddr, `SCT_OFF_CTRL_STAT))
                begin
                    n.prdata[`SCT_CS_LOW_NOCLR] = s.no_clear[0];
                    n.prdata[`SCT_CS_HIGH_NOCLR] = s.no_clear[1];
                    n.prdata[`SCT_CS_LOW_TOG] = tog_q[0];
                    n.prdata[`SCT_CS_HIGH_TOG] = tog_q[1];
                end
                // RL6: counters read back live value
                if (is_addr(paddr, `SCT_OFF_LOW_CNT))
                begin
                    n.prdata[CNT_W-1:0] = cnt_q[0];
                end
                if (is_addr(paddr, `SCT_OFF_HIGH_CNT))
                begin
                    n.prdata[CNT_W-1:0] = cnt_q[1];
                end
                if (is_addr(paddr, `SCT_OFF_LOW_CMP))
                begin
                    n.prdata[CNT_W-1:0] = s.cmp[0];
                end
                if (is_addr(paddr, `SCT_OFF_HIGH_CMP))
                begin
                    n.prdata[CNT_W-1:0] = s.cmp[1];
                end
                if (is_addr(paddr, `SCT_OFF_IRQ_STAT))
                begin
                    n.prdata[`SCT_EV_W-1:0] = s.stat;
                end
                if (is_addr(paddr, `SCT_OFF_IRQ_MASK))
                begin
                    n.prdata[`SCT_EV_W-1:0] = s.mask;
                end
            end
        end
        else if (psel && penable && s.pready)
        begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end

        // RL5: write-only clock select, reads as zero
        if (wr_fire && is_addr(paddr, `SCT_OFF_CTRL))
        begin
            n.clk_sel = sct_pkg::sct_clk_sel_t'(pwdata[`SCT_CTRL_SEL_MSB:`SCT_CTRL_SEL_LSB]);
            // restart the divide so the first tick comes a full period later
            n.presc = '0;
        end
        // RL7: match-clear inhibit per half
        if (wr_fire && is_addr(paddr, `SCT_OFF_CTRL_STAT))
        begin
            n.no_clear[0] = pwdata[`SCT_CS_LOW_NOCLR];
            n.no_clear[1] = pwdata[`SCT_CS_HIGH_NOCLR];
        end
        // RL10: compare held until software rewrites it
        if (wr_fire && is_addr(paddr, `SCT_OFF_LOW_CMP))
        begin
            n.cmp[0] = pwdata[CNT_W-1:0];
        end
        if (wr_fire && is_addr(paddr, `SCT_OFF_HIGH_CMP))
        begin
            n.cmp[1] = pwdata[CNT_W-1:0];
        end
        if (wr_fire && is_addr(paddr, `SCT_OFF_IRQ_MASK))
        begin
            n.mask = pwdata[`SCT_EV_W-1:0];
        end

        // RL12: write one clears, a fresh event wins
        if (wr_fire && is_addr(paddr, `SCT_OFF_IRQ_STAT))
        begin
            n.stat = (s.stat & ~pwdata[`SCT_EV_W-1:0]) | ev;
        end
        else
        begin
            n.stat = s.stat | ev;
        end

        // RL8: unmasked flag requests the cpu
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= ST_RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign low_toggle_out = tog_q[0];
    assign high_toggle_out = tog_q[1];

    sequence s_setup;
        psel && !penable && !pready;
    endsequence

    sequence s_access_done;
        psel && penable && pready;
    endsequence

    chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        s_setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        s_setup and !is_mapped(paddr) |=> pready && pslverr)
    else $error("unmapped address not refused");

    chk_div4_gap: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        tick && s.clk_sel == sct_pkg::SCT_CLK_DIV4 && !wr_fire
        |=> (!tick)[*3] ##1 (tick || s.clk_sel != sct_pkg::SCT_CLK_DIV4))
    else $error("divide by four spacing wrong");

    // a new select inside the gap restarts the divide, so only a still-selected thirty-two is held to it
    chk_div32_gap: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        tick && s.clk_sel == sct_pkg::SCT_CLK_DIV32 |=> (!tick || s.clk_sel != sct_pkg::SCT_CLK_DIV32)[*8])
    else $error("divide by thirty-two ticked early");

    chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // RL8
        match_q[0] |=> s.stat[`SCT_EV_LOW_MATCH])
    else $error("low match flag not set");

    chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL12
        s_access_done and pwrite and is_addr(paddr, `SCT_OFF_IRQ_STAT) and pwdata[0] and !ev[0]
        |=> !s.stat[`SCT_EV_LOW_MATCH])
    else $error("write one did not clear flag");

    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        irq == |(s.stat & s.mask))
    else $error("irq does not follow unmasked status");

    chk_ctrl_preset: assert property (@(posedge pclk) disable iff (!presetn) // RL9
        tog_wr[0] |=> low_toggle_out == $past(pwdata[`SCT_CTRL_LOW_LVL]))
    else $error("control write did not preset level");

    // read data is captured from the state seen in the setup cycle
    sequence s_read_setup;
        psel && !penable && !pready && !pwrite;
    endsequence

    chk_high_preset: assert property (@(posedge pclk) disable iff (!presetn) // RL9
        tog_wr[1] |=> high_toggle_out == $past(pwdata[`SCT_CTRL_HIGH_LVL]))
    else $error("control write did not preset high level");

    chk_ctrl_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL5
        s_read_setup and is_addr(paddr, `SCT_OFF_CTRL) |=> pready && prdata == '0)
    else $error("write-only control did not read as zero");

    chk_cnt_readback: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        s_read_setup and is_addr(paddr, `SCT_OFF_LOW_CNT) |=> prdata[CNT_W-1:0] == $past(cnt_q[0]))
    else $error("low counter read back wrong value");

    chk_low_cnt_write: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        cnt_wr[0] |=> cnt_q[0] == $past(pwdata[CNT_W-1:0]))
    else $error("low counter write did not land");

    chk_high_cnt_write: assert property (@(posedge pclk) disable iff (!presetn) // RL11
        cnt_wr[1] |=> cnt_q[1] == $past(pwdata[CNT_W-1:0]))
    else $error("high counter write did not land");

    chk_high_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // RL11
        match_q[1] |=> s.stat[`SCT_EV_HIGH_MATCH])
    else $error("high match flag not set");

    chk_ovf_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        ovf_q[0] |=> s.stat[`SCT_EV_LOW_OVF])
    else $error("low overflow flag not set");

    // the flag may only fall through a write of one to its own bit
    chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RL8
        s.stat[`SCT_EV_LOW_MATCH] && !(wr_fire && is_addr(paddr, `SCT_OFF_IRQ_STAT) && pwdata[`SCT_EV_LOW_MATCH])
        |=> s.stat[`SCT_EV_LOW_MATCH])
    else $error("low match flag fell without a clear");

    chk_cmp_held: assert property (@(posedge pclk) disable iff (!presetn) // RL10
        !(wr_fire && is_addr(paddr, `SCT_OFF_LOW_CMP)) |=> $stable(s.cmp[0]))
    else $error("low compare changed without a write");

    chk_pready_idle: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        !psel |=> !pready)
    else $error("pready high outside a transfer");

endmodule
`default_nettype wire

/* sct_mix_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sct_mix_model (
    // toggle inputs from the timer
    input wire logic low_in,
    input wire logic high_in,
    // summed level and measured spacing of edges
    output logic [1:0] mix,
    output var time low_per,
    output var time high_per
);
    time low_last = 0;
    time high_last = 0;

    // equal resistor weights; the amplifier filter is not modelled
    assign mix = {1'b0, low_in} + {1'b0, high_in};

    initial
    begin
        low_per = 0;
        high_per = 0;
    end

    always @(low_in)
    begin
        low_per = $time - low_last;
        low_last = $time;
    end

    always @(high_in)
    begin
        high_per = $time - high_last;
        high_last = $time;
    end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sct_regs.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic low_toggle_out;
    logic high_toggle_out;
    logic irq;
    time low_per;
    time high_per;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int compares = 0;

    always #2 pclk = ~pclk;

    sct_timer u_sct_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_toggle_out(low_toggle_out), .high_toggle_out(high_toggle_out), .irq(irq)
    );

    sct_mix_model u_sct_mix_model (
        .low_in(low_toggle_out), .high_in(high_toggle_out), .mix(),
        .low_per(low_per), .high_per(high_per)
    );

    task automatic stop_test;
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk({31'h0, err}, 32'h0);
        chk(rd, exp);
    endtask

    // spacing of toggle edges in ns: cmp+1 ticks of a divide-by-4 clock
    function automatic logic [31:0] per_ns(input logic [7:0] c);
        return (32'(c) + 32'h1) * 32'h10;
    endfunction

    initial
    begin
        logic [7:0] offs [8] = '{`SCT_OFF_CTRL, `SCT_OFF_CTRL_STAT, `SCT_OFF_LOW_CNT, `SCT_OFF_HIGH_CNT,
            `SCT_OFF_LOW_CMP, `SCT_OFF_HIGH_CMP, `SCT_OFF_IRQ_STAT, `SCT_OFF_IRQ_MASK};
        int div [3] = '{32, 16, 4};
        logic [7:0] c0;
        logic [7:0] cl;
        logic [7:0] ch;
        int k;
        void'($urandom(32'h34D90D55));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) rdc(offs[i], 32'h0);
        apb(1'b0, 8'h22, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        repeat (4)
        begin
            c0 = 8'($urandom);
            wr(`SCT_OFF_LOW_CNT, {24'h0, c0});
            wr(`SCT_OFF_HIGH_CNT, {24'h0, ~c0});
            rdc(`SCT_OFF_LOW_CNT, {24'h0, c0});
            rdc(`SCT_OFF_HIGH_CNT, {24'h0, ~c0});
        end
        // two reads spaced by whole tick periods must differ by exactly k
        wr(`SCT_OFF_LOW_CMP, 32'hFF);
        wr(`SCT_OFF_HIGH_CMP, 32'hFF);
        for (int s = 0; s < 3; s++)
        begin
            c0 = 8'($urandom_range(200));
            k = $urandom_range(5, 1);
            wr(`SCT_OFF_CTRL, 32'h3);
            wr(`SCT_OFF_LOW_CNT, {24'h0, c0});
            wr(`SCT_OFF_CTRL, 32'(s));
            apb(1'b0, `SCT_OFF_LOW_CNT, 32'h0);
            cl = rd[7:0];
            repeat (div[s] * k - 3) @(posedge pclk);
            rdc(`SCT_OFF_LOW_CNT, {24'h0, cl + 8'(k)});
        end
        for (int v = 0; v < 4; v++)
        begin
            wr(`SCT_OFF_CTRL, 32'(v * 4 + 3));
            @(posedge pclk);
            chk({30'h0, high_toggle_out, low_toggle_out}, 32'(v));
            rdc(`SCT_OFF_CTRL_STAT, 32'(v * 16));
        end
        cl = 8'($urandom_range(20, 2));
        ch = 8'($urandom_range(20, 2));
        wr(`SCT_OFF_CTRL, 32'h3);
        wr(`SCT_OFF_LOW_CMP, {24'h0, cl});
        wr(`SCT_OFF_HIGH_CMP, {24'h0, ch});
        wr(`SCT_OFF_LOW_CNT, 32'h0);
        wr(`SCT_OFF_HIGH_CNT, 32'h0);
        wr(`SCT_OFF_IRQ_MASK, 32'h3);
        wr(`SCT_OFF_CTRL, 32'h2);
        repeat (400) @(posedge pclk);
        chk(32'(low_per), per_ns(cl));
        chk(32'(high_per), per_ns(ch));
        chk({31'h0, irq}, 32'h1);
        rdc(`SCT_OFF_IRQ_STAT, 32'h3);
        wr(`SCT_OFF_CTRL, 32'h3);
        wr(`SCT_OFF_IRQ_STAT, 32'h3);
        rdc(`SCT_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // low half set not to clear, wraps and then runs through its match
        wr(`SCT_OFF_CTRL_STAT, 32'h1);
        wr(`SCT_OFF_LOW_CMP, 32'h2);
        wr(`SCT_OFF_HIGH_CMP, 32'hFF);
        wr(`SCT_OFF_LOW_CNT, 32'hFC);
        wr(`SCT_OFF_HIGH_CNT, 32'h0);
        wr(`SCT_OFF_IRQ_MASK, 32'h0);
        wr(`SCT_OFF_CTRL, 32'h2);
        repeat (40) @(posedge pclk);
        wr(`SCT_OFF_CTRL, 32'h3);
        rdc(`SCT_OFF_IRQ_STAT, 32'h5);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, `SCT_OFF_LOW_CNT, 32'h0);
        chk({31'h0, rd[7:0] > 8'h3}, 32'h1);
        wr(`SCT_OFF_IRQ_MASK, 32'h4);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        stop_test();
    end

    // the whole run needs under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
